/* verilog/pwm_brm_dac_generator.sv */
// Multi-channel 10-bit pulse generator with Wishbone register slave
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pwm_brm_dac_generator
	import pwm_brm_pkg::*;
#(
	parameter int NCH = 2
)(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// Wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [ADR_W-1:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// Generator pins
	output logic [NCH-1:0] PWM_OUT
);
	// ==========================================================
	// Parameter check
	generate
		if (NCH < 2 || NCH > 16 || (NCH % 2) != 0) begin : g_bad
			$error("NCH must be even, 2 to 16");
		end
	endgenerate

	// ==========================================================
	// Shared counter
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [LOW_W-1:0] low;
	logic [PER_W-1:0] period;

	// Free-running increment, wraps at 1024
	always_comb begin
		next_cnt = CNT_W'(cnt + CNT_STEP);
	end

	// Counter register
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cnt <= CNT_RESET;
		end else begin
			cnt <= next_cnt;
		end
	end

	// Low bits give the pulse position, high bits the period number
	assign low = cnt[LOW_W-1:0];
	assign period = cnt[CNT_W-1:LOW_W];

	// ==========================================================
	// Bus access decode
	logic [IDX_W-1:0] idx;
	logic acc;
	logic wr;
	logic next_ack;
	logic [31:0] next_dat;

	// One access per request; a second edge with ack high is not taken
	assign idx = ADR_I[ADR_W-1:2];
	assign acc = CYC_I && STB_I && !ACK_O;
	assign wr = acc && WE_I && SEL_I[0];

	// ==========================================================
	// Per-channel registers
	logic [WEIGHT_W-1:0] weight [NCH];
	logic [BRM_W-1:0] brm [NCH];
	logic [NCH-1:0] output_inversion;
	logic [NCH-1:0] w_hit;
	logic [NCH-1:0] b_hit;

	// Register offsets inside one pair: multiplier byte, then the odd channel's weight
	localparam int BRM_OFS = 1;
	localparam int ODD_OFS = 2;

	generate
		for (genvar k = 0; k < NCH; k++) begin : g_ch
			localparam logic [IDX_W-1:0] W_IDX =
				IDX_W'(IDX_PAIR_BASE + PAIR_STRIDE * (k / 2) + ODD_OFS * (k % 2));
			localparam logic [IDX_W-1:0] B_IDX =
				IDX_W'(IDX_PAIR_BASE + PAIR_STRIDE * (k / 2) + BRM_OFS);
			localparam int NIB = BRM_W * (k % 2);
			logic [WEIGHT_W-1:0] next_weight;
			logic [BRM_W-1:0] next_brm;
			logic next_inv;

			assign w_hit[k] = (idx == W_IDX);
			assign b_hit[k] = (idx == B_IDX);

			// Software writes to the weight and shared multiplier bytes
			always_comb begin
				next_weight = weight[k];
				next_inv = output_inversion[k];
				next_brm = brm[k];
				if (wr && w_hit[k]) begin
					next_weight = DAT_I[WEIGHT_W-1:0];
					next_inv = DAT_I[INV_BIT];
				end
				if (wr && b_hit[k]) begin
					next_brm = DAT_I[NIB +: BRM_W];
				end
			end

			// Channel settings registers
			always_ff @(posedge CLK) begin
				if (!RESETN) begin
					weight[k] <= WEIGHT_RESET;
					output_inversion[k] <= 1'b0;
					brm[k] <= BRM_RESET;
				end else begin
					weight[k] <= next_weight;
					output_inversion[k] <= next_inv;
					brm[k] <= next_brm;
				end
			end

			// Output generator of this channel
			dac_channel u_ch (
				.clk(CLK),
				.resetn(RESETN),
				.low(low),
				.period(period),
				.weight(weight[k]),
				.brm(brm[k]),
				.output_inversion(output_inversion[k]),
				.pwm_out(PWM_OUT[k])
			);
		end
	endgenerate

	// ==========================================================
	// Read data and acknowledge
	always_comb begin
		next_ack = acc;
		next_dat = 32'h0000_0000;
		if (acc && !WE_I) begin
			for (int k = 0; k < NCH; k++) begin
				if (w_hit[k]) begin
					next_dat[WREG_ONE_BIT] = 1'b1;
					next_dat[INV_BIT] = output_inversion[k];
					next_dat[WEIGHT_W-1:0] = weight[k];
				end
				if (b_hit[k]) begin
					next_dat[BRM_W * (k % 2) +: BRM_W] = brm[k];
				end
			end
			if (idx == IDX_STATUS) begin
				next_dat[STAT_CNT_LSB +: CNT_W] = cnt;
				next_dat[NCH-1:0] = PWM_OUT;
			end
		end
	end

	// Bus answer registers; unmapped reads return zero
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0000_0000;
		end else begin
			ACK_O <= next_ack;
			DAT_O <= next_dat;
		end
	end

	// ==========================================================
	// Checks
	sequence s_req;
		CYC_I && STB_I && !ACK_O;
	endsequence

	sequence s_answer;
		ACK_O ##1 !ACK_O;
	endsequence

	property p_ack;
		@(posedge CLK) disable iff (!RESETN)
		s_req |=> s_answer;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");

	property p_cnt_step;
		@(posedge CLK) disable iff (!RESETN)
		$past(RESETN) |-> (cnt == CNT_W'($past(cnt) + CNT_STEP));
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

	property p_period_len;
		@(posedge CLK) disable iff (!RESETN)
		($past(RESETN) && low == LOW_ZERO) |-> ##64 (low == LOW_ZERO);
	endproperty
	a_period_len: assert property (p_period_len) else $error("base period not 64");

	property p_reset_low;
		@(posedge CLK)
		$rose(RESETN) |-> (PWM_OUT == '0);
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("pins not low after reset");

	property p_one_bit;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (!WE_I && idx == IDX_PAIR_BASE)) |=> DAT_O[WREG_ONE_BIT];
	endproperty
	a_one_bit: assert property (p_one_bit) else $error("weight bit 7 not one");

	property p_brm_hi;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (WE_I && SEL_I[0] && idx == IDX_PAIR_BASE + 10'h001))
			|=> (brm[1] == $past(DAT_I[7:4]) && brm[0] == $past(DAT_I[3:0]));
	endproperty
	a_brm_hi: assert property (p_brm_hi) else $error("multiplier nibbles misplaced");

	property p_weight_wr;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (WE_I && SEL_I[0] && idx == IDX_PAIR_BASE))
			|=> (weight[0] == $past(DAT_I[5:0]) && output_inversion[0] == $past(DAT_I[6]));
	endproperty
	a_weight_wr: assert property (p_weight_wr) else $error("weight write lost");

	property p_status_cnt;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (!WE_I && idx == IDX_STATUS))
			|=> (DAT_O[STAT_CNT_LSB +: CNT_W] == CNT_W'(cnt - CNT_STEP));
	endproperty
	a_status_cnt: assert property (p_status_cnt) else $error("status counter wrong");

	property p_unmapped;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (!WE_I && idx == 10'h000)) |=> (DAT_O == 32'h0000_0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_ack_cause;
		@(posedge CLK) disable iff (!RESETN)
		ACK_O |-> $past(CYC_I && STB_I && !ACK_O);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");

	property p_dat_idle;
		@(posedge CLK) disable iff (!RESETN)
		!ACK_O |-> (DAT_O == 32'h0000_0000);
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

	property p_cnt_reset;
		@(posedge CLK)
		$rose(RESETN) |-> (cnt == CNT_RESET);
	endproperty
	a_cnt_reset: assert property (p_cnt_reset) else $error("counter not reset");

	property p_lane_off;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (WE_I && !SEL_I[0] && idx == IDX_PAIR_BASE)) |=> $stable(weight[0]);
	endproperty
	a_lane_off: assert property (p_lane_off) else $error("write with lane off landed");

	property p_odd_wr;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (WE_I && SEL_I[0] && idx == IDX_PAIR_BASE + 10'h002))
			|=> (weight[1] == $past(DAT_I[5:0]) && output_inversion[1] == $past(DAT_I[6]));
	endproperty
	a_odd_wr: assert property (p_odd_wr) else $error("odd weight write lost");

	property p_odd_read;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (!WE_I && idx == IDX_PAIR_BASE + 10'h002))
			|=> (DAT_O[WREG_ONE_BIT] && DAT_O[WEIGHT_W-1:0] == $past(weight[1]));
	endproperty
	a_odd_read: assert property (p_odd_read) else $error("odd weight read wrong");

	property p_brm_hold;
		@(posedge CLK) disable iff (!RESETN)
		($past(RESETN) && !$past(CYC_I && STB_I && WE_I)) |-> $stable(brm[0]);
	endproperty
	a_brm_hold: assert property (p_brm_hold) else $error("unwritten multiplier moved");

	property p_status_pins;
		@(posedge CLK) disable iff (!RESETN)
		(s_req and (!WE_I && idx == IDX_STATUS)) |=> (DAT_O[NCH-1:0] == $past(PWM_OUT));
	endproperty
	a_status_pins: assert property (p_status_pins) else $error("status pins wrong");
endmodule
`default_nettype wire

/* verilog/pwm_brm_pkg.sv */
// Shared constants of the pulse width / rate multiplier generator
`default_nettype none
package pwm_brm_pkg;
	// ==========================================================
	// Counter and field widths
	localparam int CNT_W = 10;
	localparam int LOW_W = 6;
	localparam int PER_W = 4;
	localparam int WEIGHT_W = 6;
	localparam int BRM_W = 4;
	localparam logic [5:0] LOW_MAX = 6'h3f;
	localparam logic [5:0] LOW_ZERO = 6'h00;
	localparam logic [9:0] CNT_RESET = 10'h000;
	localparam logic [9:0] CNT_STEP = 10'h001;
	// ==========================================================
	// Period selection codes of the rate multiplier
	localparam logic [3:0] PER_EIGHT = 4'h8;
	localparam logic [2:0] PER_MOD8_FOUR = 3'h4;
	localparam logic [1:0] PER_MOD4_TWO = 2'h2;
	localparam logic [3:0] PER_LAST = 4'hf;
	// ==========================================================
	// Register layout
	localparam int WREG_ONE_BIT = 7;
	localparam int INV_BIT = 6;
	localparam logic [7:0] WREG_RESET = 8'h80;
	localparam logic [5:0] WEIGHT_RESET = 6'h00;
	localparam logic [3:0] BRM_RESET = 4'h0;
	localparam int IDX_W = 10;
	localparam int ADR_W = 12;
	localparam logic [9:0] IDX_PAIR_BASE = 10'h04d;
	localparam int PAIR_STRIDE = 3;
	localparam logic [9:0] IDX_STATUS = 10'h04c;
	localparam int STAT_CNT_LSB = 16;
endpackage
`default_nettype wire

/* verilog/dac_channel.sv */
// One output channel: set at roll-over, clear at weight match, widened periods
`timescale 1ns/1ps
`default_nettype none
module dac_channel
	import pwm_brm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Shared counter slices
	input wire logic [LOW_W-1:0] low,
	input wire logic [PER_W-1:0] period,
	// Channel settings
	input wire logic [WEIGHT_W-1:0] weight,
	input wire logic [BRM_W-1:0] brm,
	input wire logic output_inversion,
	// Pin level
	output logic pwm_out
);
	// ==========================================================
	// Widening selection
	logic [PER_W-1:0] next_period;
	logic sel;
	logic extra;
	logic level;
	logic next_level;

	// Period that follows the current one, and whether it is widened
	always_comb begin
		next_period = PER_W'(period + 4'h1);
		sel = (brm[0] && next_period == PER_EIGHT)
			|| (brm[1] && next_period[2:0] == PER_MOD8_FOUR)
			|| (brm[2] && next_period[1:0] == PER_MOD4_TWO)
			|| (brm[3] && next_period[0]);
		// Extra clock sits just before the ordinary pulse start
		extra = (low == LOW_MAX) && sel;
	end

	// ==========================================================
	// Level: set on roll-over, clear on match
	always_comb begin
		next_level = level;
		if (extra) begin
			next_level = 1'b1;
		end else if (low == weight) begin
			next_level = 1'b0;
		end else if (low == LOW_ZERO) begin
			next_level = 1'b1;
		end
	end

	// Level and pin registers; pin low under reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			level <= 1'b0;
			pwm_out <= 1'b0;
		end else begin
			level <= next_level;
			pwm_out <= next_level ^ output_inversion;
		end
	end

	// ==========================================================
	// Checks
	sequence s_rollover;
		low == LOW_ZERO && weight != WEIGHT_RESET;
	endsequence

	property p_set;
		@(posedge clk) disable iff (!resetn)
		s_rollover |=> level;
	endproperty
	a_set: assert property (p_set) else $error("level not set at roll-over");

	property p_clear;
		@(posedge clk) disable iff (!resetn)
		(low == weight && !extra) |=> !level;
	endproperty
	a_clear: assert property (p_clear) else $error("level not cleared at match");

	property p_widen8;
		@(posedge clk) disable iff (!resetn)
		(low == LOW_MAX && brm == 4'h1 && period == 4'h7) |=> level;
	endproperty
	a_widen8: assert property (p_widen8) else $error("period 8 not widened");

	property p_union;
		@(posedge clk) disable iff (!resetn)
		(low == LOW_MAX && brm == 4'h6 && period == 4'h3) |=> level;
	endproperty
	a_union: assert property (p_union) else $error("combined bits not widened");

	property p_no_zero;
		@(posedge clk) disable iff (!resetn)
		(low == LOW_MAX && period == PER_LAST && weight == LOW_MAX) |=> !level;
	endproperty
	a_no_zero: assert property (p_no_zero) else $error("period 0 widened");

	property p_zero_cfg;
		@(posedge clk) disable iff (!resetn)
		(low == LOW_ZERO && weight == 6'h00 && brm == 4'h0) |=> (pwm_out == $past(output_inversion));
	endproperty
	a_zero_cfg: assert property (p_zero_cfg) else $error("zero setting not steady");

	property p_polarity;
		@(posedge clk) disable iff (!resetn)
		$past(resetn) |-> (pwm_out == (level ^ $past(output_inversion)));
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin polarity wrong");
endmodule
`default_nettype wire

/* test/pwm_rc_load.sv */
// Behavioural RC filter load that integrates the charge one pin delivers
`timescale 1ns/1ps
`default_nettype none
module pwm_rc_load (
	// Clock and window control
	input wire logic clk,
	input wire logic clear,
	// Pin level from the generator
	input wire logic level,
	// Charge over one 1024-clock window, pulse shape over two such windows
	output var int highs,
	output var int min_run,
	output var int max_run
);
	int age;
	int run;

	// ==========================================================
	// Charge integration
	// A run already under way at clear is poisoned so a cut pulse never counts
	always @(posedge clk) begin
		if (clear) begin
			age <= 0;
			highs <= 0;
			min_run <= 9999;
			max_run <= 0;
			run <= level ? -100000 : 0;
		end else begin
			age <= age + 1;
			if (age < 1024 && level)
				highs <= highs + 1;
			if (level)
				run <= run + 1;
			else begin
				// Two full counter cycles, so every pulse kind is seen whole at least once
				if (run > 0 && age < 2048) begin
					if (run < min_run)
						min_run <= run;
					if (run > max_run)
						max_run <= run;
				end
				run <= 0;
			end
		end
	end
endmodule
`default_nettype wire

/* test/test_pwm_brm_dac_generator.sv */
// Self-checking testbench of the pulse width / rate multiplier generator
`timescale 1ns/1ps
`default_nettype none
module test_pwm_brm_dac_generator
	import pwm_brm_pkg::*;
;
	logic CLK, RESETN, CYC_I, STB_I, WE_I, ACK_O, clear;
	logic [11:0] ADR_I;
	logic [3:0] SEL_I;
	logic [31:0] DAT_I, DAT_O, rd;
	logic [1:0] PWM_OUT;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int i, k;
	int highs[2], min_run[2], max_run[2];

	// ==========================================================
	// Design and one filter load per pin
	pwm_brm_dac_generator #(.NCH(2)) dut (.CLK(CLK), .RESETN(RESETN), .CYC_I(CYC_I),
		.STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
		.DAT_O(DAT_O), .ACK_O(ACK_O), .PWM_OUT(PWM_OUT));
	pwm_rc_load load0 (.clk(CLK), .clear(clear), .level(PWM_OUT[0]), .highs(highs[0]),
		.min_run(min_run[0]), .max_run(max_run[0]));
	pwm_rc_load load1 (.clk(CLK), .clear(clear), .level(PWM_OUT[1]), .highs(highs[1]),
		.min_run(min_run[1]), .max_run(max_run[1]));

	// ==========================================================
	// Clock and hang guard
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_count++;
			final_report;
		end
	end

	// ==========================================================
	// Helpers
	task final_report;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic single Wishbone cycle, held until ack is sampled
	task wb(input logic we, input logic [11:0] adr, input logic [3:0] sel, input logic [7:0] dat);
		@(posedge CLK);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= we;
		ADR_I <= adr;
		SEL_I <= sel;
		DAT_I <= {24'h000000, dat};
		@(posedge CLK);
		while (ACK_O !== 1'b1)
			@(posedge CLK);
		rd = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
	endtask

	task rdchk(input logic [11:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 4'h1, 8'h00);
		check(rd, exp);
	endtask

	// Charge per 1024 clocks: 16 ordinary pulses plus one clock per widened period
	function int exp_highs(input logic [5:0] wv, input logic [3:0] bv, input logic iv);
		int n;
		n = 16 * wv + bv;
		return iv ? 1024 - n : n;
	endfunction

	task pin_chk(input int c, input logic [5:0] wv, input logic [3:0] bv, input logic iv);
		check(highs[c], exp_highs(wv, bv, iv));
		if (!iv && wv > 0 && wv < 63) begin
			check(min_run[c], wv);
			check(max_run[c], wv + (bv != 4'h0));
		end
	endtask

	// Program both channels, read back, then measure charge over one counter cycle and pulse shape over two
	task run(input logic [5:0] w0, input logic [3:0] b0, input logic i0,
		input logic [5:0] w1, input logic [3:0] b1, input logic i1);
		wb(1'b1, 12'h134, 4'h1, {1'b0, i0, w0});
		wb(1'b1, 12'h138, 4'h1, {b1, b0});
		wb(1'b1, 12'h13c, 4'h1, {1'b0, i1, w1});
		rdchk(12'h134, {24'h0, 1'b1, i0, w0});
		rdchk(12'h138, {24'h0, b1, b0});
		rdchk(12'h13c, {24'h0, 1'b1, i1, w1});
		repeat (70) @(posedge CLK);
		clear <= 1'b1;
		@(posedge CLK);
		clear <= 1'b0;
		repeat (2100) @(posedge CLK);
		pin_chk(0, w0, b0, i0);
		pin_chk(1, w1, b1, i1);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		RESETN = 1'b0;
		CYC_I = 1'b0;
		STB_I = 1'b0;
		WE_I = 1'b0;
		ADR_I = 12'h000;
		SEL_I = 4'h0;
		DAT_I = 32'h0;
		clear = 1'b1;
		k = $urandom(32'hcd60d5e1);
		repeat (2) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		check({30'h0, PWM_OUT}, 32'h0);
		rdchk(12'h134, 32'h80);
		rdchk(12'h138, 32'h00);
		rdchk(12'h13c, 32'h80);
		check({30'h0, PWM_OUT}, 32'h0);
		// Unmapped place and a write with its byte lane off are both dropped
		wb(1'b1, 12'h400, 4'h1, 8'h3f);
		rdchk(12'h400, 32'h0);
		wb(1'b1, 12'h134, 4'h0, 8'h3f);
		rdchk(12'h134, 32'h80);
		rdchk(12'h000, 32'h0);
		// Two status reads taken three clocks apart see the counter move by three
		wb(1'b0, 12'h130, 4'h1, 8'h00);
		k = rd[STAT_CNT_LSB +: CNT_W];
		wb(1'b0, 12'h130, 4'h1, 8'h00);
		check({22'h0, rd[STAT_CNT_LSB +: CNT_W] - k[CNT_W-1:0]}, 32'h3);
		run(6'h00, 4'h0, 1'b0, 6'h00, 4'h0, 1'b1);
		run(6'h3f, 4'hf, 1'b0, 6'h18, 4'h6, 1'b0);
		run(6'h00, 4'h8, 1'b0, 6'h01, 4'h1, 1'b1);
		run(6'h01, 4'h2, 1'b0, 6'h3e, 4'h4, 1'b0);
		for (i = 0; i < 6; i++)
			run($urandom % 64, $urandom % 16, $urandom % 2, $urandom % 64, $urandom % 16,
				$urandom % 2);
		final_report;
	end
endmodule
`default_nettype wire
